// ==== logic/power_mode_wakeup_control_map.vh ====
// Register indices, field positions, reset values and settle counts
// for the operating-mode and wake-up controller.
// Assumes byte address = 4 * index on a 32-bit AXI4-Lite bus.
`ifndef POWER_MODE_WAKEUP_CONTROL_MAP_VH
`define POWER_MODE_WAKEUP_CONTROL_MAP_VH

// Register indices
`define IDX_POWER_CONTROL 10'h087
`define IDX_PORT1_WAKE_ENABLE 10'h091
`define IDX_WAKE_CONFIG 10'h0c0
`define IDX_SOURCE_ENABLE 10'h0c1
`define IDX_SOURCE_FLAG 10'h0c2
`define IDX_MODE_STATUS 10'h0c3
`define IDX_INT_STATUS 10'h0c4
`define IDX_INT_CLEAR 10'h0c5
`define IDX_INT_ENABLE 10'h0c6

// power_control fields
`define PC_IDLE_BIT 0
`define PC_STOP_BIT 1
`define PC_GP_FLAG_BIT 2
`define PC_RESET 8'h00
`define PORT1_WAKE_ENABLE_RESET 8'h00

// wake_config fields
`define CFG_GLOBAL_IE_BIT 0
`define CFG_EXT_OSC_BIT 1
`define CFG_RESET 8'h00

// source_flag: bits 6:0 peripheral events, bit 7 pin wake
`define FLAG_PIN_WAKE_BIT 7

// int_status events
`define EV_STOP_WAKE 0
`define EV_IDLE_WAKE 1
`define EV_LOW_POWER_ENTRY 2

// Oscillator settle counts
`define SETTLE_EXT_HS_CLKS 2048
`define SETTLE_INT_HS_CLKS 64
`define SETTLE_LS_CLKS 5

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ==== logic/power_mode_wakeup_control.v ====
// Operating-mode controller: normal, IDLE and STOP with pin and
// interrupt wake-up, oscillator settle delay and AXI4-Lite registers.
// Assumes pins, events and the slow-clock tick are synchronous to
// sys_clk; high-speed clocks are counted as sys_clk cycles.
//
// Notes on behaviour
// - Normal mode after reset release
// - Every wake-up returns to normal mode
// - Normal: both oscillators on, fast clock
// - Stop bit set enters STOP
// - Hardware clears stop bit on wake
// - STOP halts oscillators, keeps all state
// - STOP exits only on port pin change
// - Idle bit set enters IDLE
// - Hardware clears idle bit on wake
// - IDLE keeps system clock and peripherals
// - IDLE also wakes on enabled interrupt
// - Wake event sets its request flag
// - External oscillator: 2048 fast plus 5 slow
// - Internal oscillator: 64 fast plus 5 slow
// - Pin wake on rising or falling change
// - Port 1 pin wakes only when enabled
// - Flag on event; request needs both enables
// - Power control: stop bit1, idle bit0
`include "power_mode_wakeup_control_map.vh"
`default_nettype none

module power_mode_wakeup_control #(
    parameter ADDR_W = 12,
    parameter EXT_HS_CLKS = `SETTLE_EXT_HS_CLKS,
    parameter INT_HS_CLKS = `SETTLE_INT_HS_CLKS,
    parameter LS_CLKS = `SETTLE_LS_CLKS
) (
    // Clock and reset
    input wire sys_clk,
    input wire reset,
    // AXI4-Lite write address and data
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    output reg [1:0] s_axi_bresp,
    // AXI4-Lite read
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    // Wake pins and event sources
    input wire [7:0] port0_pin,
    input wire [7:0] port1_pin,
    input wire [6:0] source_event,
    input wire slow_clk_tick,
    // Mode and clock controls
    output reg cpu_run,
    output reg fast_osc_en,
    output reg slow_osc_en,
    output reg sys_clk_en,
    output reg periph_clk_en,
    output reg [2:0] mode_state,
    // Interrupt request to the CPU and block interrupt
    output wire cpu_irq_req,
    output wire irq
);

    localparam [4:0] ST_NORMAL = 5'b00001;
    localparam [4:0] ST_IDLE = 5'b00010;
    localparam [4:0] ST_STOP = 5'b00100;
    localparam [4:0] ST_SETTLE_HS = 5'b01000;
    localparam [4:0] ST_SETTLE_LS = 5'b10000;
    localparam [11:0] EXT_HS_LAST = EXT_HS_CLKS[11:0] - 12'h001;
    localparam [11:0] INT_HS_LAST = INT_HS_CLKS[11:0] - 12'h001;
    localparam [2:0] LS_LAST = LS_CLKS[2:0] - 3'h1;

    function hit;
        input [ADDR_W-1:0] addr;
        input [9:0] idx;
        begin
            hit = (addr[ADDR_W-1:2] == idx[ADDR_W-3:0]);
        end
    endfunction

    function mapped;
        input [ADDR_W-1:0] addr;
        begin
            mapped = hit(addr, `IDX_POWER_CONTROL) |
                hit(addr, `IDX_PORT1_WAKE_ENABLE) |
                hit(addr, `IDX_WAKE_CONFIG) |
                hit(addr, `IDX_SOURCE_ENABLE) |
                hit(addr, `IDX_SOURCE_FLAG) |
                hit(addr, `IDX_MODE_STATUS) |
                hit(addr, `IDX_INT_STATUS) |
                hit(addr, `IDX_INT_CLEAR) |
                hit(addr, `IDX_INT_ENABLE);
        end
    endfunction

    reg [4:0] state_q, state_d;
    reg [11:0] hs_cnt_q, hs_cnt_d;
    reg [2:0] ls_cnt_q, ls_cnt_d;
    reg [7:0] power_control_q;
    reg [7:0] port1_wake_enable_q;
    reg [7:0] wake_config_q;
    reg [7:0] source_enable_q;
    reg [7:0] source_flag_q;
    reg [2:0] int_status_q;
    reg [2:0] int_enable_q;
    reg [7:0] port0_prev_q, port1_prev_q;
    reg aw_full_q, w_full_q;
    reg [ADDR_W-1:0] aw_addr_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;

    // Bus handshake
    assign s_axi_awready = ~aw_full_q & ~s_axi_bvalid;
    assign s_axi_wready = ~w_full_q & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;

    wire do_write = aw_full_q & w_full_q & ~s_axi_bvalid;
    wire wr_lo = do_write & w_strb_q[0];
    wire wr_pc = wr_lo & hit(aw_addr_q, `IDX_POWER_CONTROL);
    wire wr_p1 = wr_lo & hit(aw_addr_q, `IDX_PORT1_WAKE_ENABLE);
    wire wr_cfg = wr_lo & hit(aw_addr_q, `IDX_WAKE_CONFIG);
    wire wr_sen = wr_lo & hit(aw_addr_q, `IDX_SOURCE_ENABLE);
    wire wr_sfl = wr_lo & hit(aw_addr_q, `IDX_SOURCE_FLAG);
    wire wr_icl = wr_lo & hit(aw_addr_q, `IDX_INT_CLEAR);
    wire wr_ien = wr_lo & hit(aw_addr_q, `IDX_INT_ENABLE);

    // Either edge on port 0, or on an enabled port 1 pin
    wire [7:0] p0_change = port0_pin ^ port0_prev_q;
    wire [7:0] p1_change = (port1_pin ^ port1_prev_q) &
        port1_wake_enable_q;
    wire pin_wake = (|p0_change) | (|p1_change);

    wire global_ie = wake_config_q[`CFG_GLOBAL_IE_BIT];
    wire [7:0] new_flags = {pin_wake, source_event};
    wire [7:0] pending = source_flag_q & source_enable_q;
    assign cpu_irq_req = global_ie & (|pending);
    wire int_wake = cpu_irq_req | (global_ie &
        (|(new_flags & source_enable_q)));

    wire stop_req = power_control_q[`PC_STOP_BIT];
    wire idle_req = power_control_q[`PC_IDLE_BIT];
    wire ext_osc = wake_config_q[`CFG_EXT_OSC_BIT];

    // Mode sequencing
    always @* begin
        state_d = state_q;
        hs_cnt_d = hs_cnt_q;
        ls_cnt_d = ls_cnt_q;
        case (state_q)
            ST_NORMAL: begin
                if (stop_req) begin
                    state_d = ST_STOP;
                end else if (idle_req) begin
                    state_d = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (pin_wake | int_wake) begin
                    state_d = ST_NORMAL;
                end
            end
            ST_STOP: begin
                if (pin_wake) begin
                    state_d = ST_SETTLE_HS;
                    hs_cnt_d = 12'h000;
                end
            end
            ST_SETTLE_HS: begin
                hs_cnt_d = hs_cnt_q + 12'h001;
                if ((ext_osc & hs_cnt_q == EXT_HS_LAST) |
                    (~ext_osc & hs_cnt_q == INT_HS_LAST)) begin
                    state_d = ST_SETTLE_LS;
                    ls_cnt_d = 3'h0;
                end
            end
            ST_SETTLE_LS: begin
                if (slow_clk_tick) begin
                    ls_cnt_d = ls_cnt_q + 3'h1;
                    if (ls_cnt_q == LS_LAST) begin
                        state_d = ST_NORMAL;
                    end
                end
            end
            default: begin
                state_d = ST_NORMAL;
            end
        endcase
    end

    wire wake_idle = (state_q == ST_IDLE) & (state_d == ST_NORMAL);
    wire wake_stop = (state_q == ST_STOP) & (state_d == ST_SETTLE_HS);
    wire wake_done = (state_q == ST_SETTLE_LS) & (state_d == ST_NORMAL);
    wire enter_lp = (state_q == ST_NORMAL) & (state_d != ST_NORMAL);

    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_q <= ST_NORMAL;
            hs_cnt_q <= 12'h000;
            ls_cnt_q <= 3'h0;
            port0_prev_q <= 8'h00;
            port1_prev_q <= 8'h00;
        end else begin
            state_q <= state_d;
            hs_cnt_q <= hs_cnt_d;
            ls_cnt_q <= ls_cnt_d;
            port0_prev_q <= port0_pin;
            port1_prev_q <= port1_pin;
        end
    end

    // Clock and run controls per mode
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cpu_run <= 1'b0;
            fast_osc_en <= 1'b1;
            slow_osc_en <= 1'b1;
            sys_clk_en <= 1'b0;
            periph_clk_en <= 1'b0;
            mode_state <= 3'b000;
        end else begin
            // normal: both oscillators, fast system clock
            cpu_run <= state_d == ST_NORMAL;
            // STOP halts every oscillator, state is retained
            fast_osc_en <= (state_d != ST_STOP);
            slow_osc_en <= (state_d != ST_STOP) &
                (state_d != ST_SETTLE_HS);
            // IDLE keeps system clock and peripherals alive
            sys_clk_en <= (state_d == ST_NORMAL) | (state_d == ST_IDLE);
            periph_clk_en <= (state_d == ST_NORMAL) |
                (state_d == ST_IDLE);
            mode_state <= {state_d == ST_STOP ||
                state_d == ST_SETTLE_HS || state_d == ST_SETTLE_LS,
                state_d == ST_IDLE, state_d == ST_NORMAL};
        end
    end

    // Software registers
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            power_control_q <= `PC_RESET;
            port1_wake_enable_q <= `PORT1_WAKE_ENABLE_RESET;
            wake_config_q <= `CFG_RESET;
            source_enable_q <= 8'h00;
            source_flag_q <= 8'h00;
            int_status_q <= 3'b000;
            int_enable_q <= 3'b000;
        end else begin
            if (wr_pc) begin
                power_control_q <= {5'b00000, w_data_q[2:0]};
            end else if (wake_stop) begin
                power_control_q[`PC_STOP_BIT] <= 1'b0;
                power_control_q[`PC_IDLE_BIT] <= 1'b0;
            end else if (wake_idle) begin
                power_control_q[`PC_IDLE_BIT] <= 1'b0;
            end
            if (wr_p1) begin
                port1_wake_enable_q <= w_data_q[7:0];
            end
            if (wr_cfg) begin
                wake_config_q <= {6'b000000, w_data_q[1:0]};
            end
            if (wr_sen) begin
                source_enable_q <= w_data_q[7:0];
            end
            // Write one clears a flag; a new event wins
            source_flag_q <= (source_flag_q &
                ~({8{wr_sfl}} & w_data_q[7:0])) | new_flags;
            int_status_q <= (int_status_q &
                ~({3{wr_icl}} & w_data_q[2:0])) |
                {enter_lp, wake_idle, wake_done};
            if (wr_ien) begin
                int_enable_q <= w_data_q[2:0];
            end
        end
    end

    assign irq = |(int_status_q & int_enable_q);

    // Write channel capture and response
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_addr_q <= {ADDR_W{1'b0}};
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_full_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_full_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(aw_addr_q) &
                    ~hit(aw_addr_q, `IDX_MODE_STATUS) &
                    ~hit(aw_addr_q, `IDX_INT_STATUS) ?
                    `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read channel
    reg [7:0] rd_val;
    always @* begin
        rd_val = 8'h00;
        if (hit(s_axi_araddr, `IDX_POWER_CONTROL)) begin
            rd_val = power_control_q;
        end else if (hit(s_axi_araddr, `IDX_PORT1_WAKE_ENABLE)) begin
            rd_val = port1_wake_enable_q;
        end else if (hit(s_axi_araddr, `IDX_WAKE_CONFIG)) begin
            rd_val = wake_config_q;
        end else if (hit(s_axi_araddr, `IDX_SOURCE_ENABLE)) begin
            rd_val = source_enable_q;
        end else if (hit(s_axi_araddr, `IDX_SOURCE_FLAG)) begin
            rd_val = source_flag_q;
        end else if (hit(s_axi_araddr, `IDX_MODE_STATUS)) begin
            rd_val = {3'b000, state_q};
        end else if (hit(s_axi_araddr, `IDX_INT_STATUS)) begin
            rd_val = {5'b00000, int_status_q};
        end else if (hit(s_axi_araddr, `IDX_INT_ENABLE)) begin
            rd_val = {5'b00000, int_enable_q};
        end
    end

    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else begin
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rd_val};
                s_axi_rresp <= mapped(s_axi_araddr) ?
                    `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// ==== dv/power_mode_wakeup_control_properties.sv ====
// Checker for the mode controller: mode, clock enables and settling.
// Assumes it is bound to the controller top with matching parameters.
`default_nettype none
module power_mode_wakeup_control_properties #(
    parameter int INT_HS_CLKS = 64,
    parameter int LS_CLKS = 5
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Wake pins and slow tick
    input wire logic [7:0] port0_pin,
    input wire logic [7:0] port1_pin,
    input wire logic slow_clk_tick,
    // Mode outputs
    input wire logic cpu_run,
    input wire logic fast_osc_en,
    input wire logic slow_osc_en,
    input wire logic sys_clk_en,
    input wire logic periph_clk_en,
    input wire logic [2:0] mode_state
);
    timeunit 1ns;
    timeprecision 1ps;
    int settle_q;

    // Cycles since the last STOP cycle
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset)
            settle_q <= 0;
        else if (!fast_osc_en)
            settle_q <= 0;
        else
            settle_q <= settle_q + 1;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    reset_to_normal_a: assert property ($past(reset) |=>
        mode_state == 3'b001 && cpu_run) else $error("no normal mode");
    normal_clocks_a: assert property (mode_state == 3'b001 |->
        cpu_run && fast_osc_en && slow_osc_en && sys_clk_en)
        else $error("normal mode clocks wrong");
    stop_halt_a: assert property (!fast_osc_en |->
        mode_state == 3'b100 && !slow_osc_en && !cpu_run && !sys_clk_en
        && !periph_clk_en) else $error("stop mode not halted");
    idle_clocks_a: assert property (mode_state == 3'b010 |->
        !cpu_run && sys_clk_en && periph_clk_en && fast_osc_en)
        else $error("idle mode clocks wrong");
    stop_pin_exit_a: assert property ($rose(fast_osc_en) |->
        $past(port0_pin) != $past(port0_pin, 2) ||
        $past(port1_pin) != $past(port1_pin, 2))
        else $error("stop left without pin change");
    stop_hold_a: assert property (!fast_osc_en &&
        $stable(port0_pin) && $stable(port1_pin) |=> !fast_osc_en)
        else $error("stop left on quiet pins");
    wake_normal_a: assert property ($fell(mode_state[2]) ||
        $fell(mode_state[1]) |-> mode_state == 3'b001)
        else $error("wake not to normal");
    settle_time_a: assert property ($rose(cpu_run) &&
        $past(mode_state[2]) |-> $past(slow_clk_tick) &&
        settle_q >= INT_HS_CLKS + LS_CLKS) else $error("settle too short");
endmodule
bind power_mode_wakeup_control power_mode_wakeup_control_properties #(
    .INT_HS_CLKS(INT_HS_CLKS),
    .LS_CLKS(LS_CLKS)
) u_props (
    .sys_clk(sys_clk),
    .reset(reset),
    .port0_pin(port0_pin),
    .port1_pin(port1_pin),
    .slow_clk_tick(slow_clk_tick),
    .cpu_run(cpu_run),
    .fast_osc_en(fast_osc_en),
    .slow_osc_en(slow_osc_en),
    .sys_clk_en(sys_clk_en),
    .periph_clk_en(periph_clk_en),
    .mode_state(mode_state)
);
`default_nettype wire

// ==== dv/pin_event_model.sv ====
// Model of the wake pins, peripheral events and slow oscillator.
// Assumes the bench calls its tasks; changes land after sys_clk edges.
`default_nettype none
module pin_event_model (
    // Clock and oscillator enable
    input wire logic sys_clk,
    input wire logic slow_osc_en,
    // Pins, events and slow tick
    output logic [7:0] port0_pin,
    output logic [7:0] port1_pin,
    output logic [6:0] source_event,
    output logic slow_clk_tick
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] div_q;

    initial begin
        port0_pin = 8'h00;
        port1_pin = 8'h00;
        source_event = 7'h00;
        slow_clk_tick = 1'b0;
        div_q = 2'h0;
    end

    // Slow clock is one tick in three and stops with its enable
    always @(posedge sys_clk) begin
        div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
        slow_clk_tick <= slow_osc_en && div_q == 2'h2;
    end

    task flip0(input int b);
        @(posedge sys_clk);
        port0_pin[b] <= ~port0_pin[b];
    endtask

    task flip1(input int b);
        @(posedge sys_clk);
        port1_pin[b] <= ~port1_pin[b];
    endtask

    task pulse(input int b);
        @(posedge sys_clk);
        source_event[b] <= 1'b1;
        @(posedge sys_clk);
        source_event[b] <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== dv/power_mode_wakeup_control_bench.sv ====
// Bench for the mode controller: bus tasks and mode sequences.
// Assumes the pin model drives pins, events and slow ticks.
`default_nettype none
module power_mode_wakeup_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HS = 4;
    localparam int EXT = 8;
    localparam int LS = 2;
    localparam logic [11:0] a_pc = 12'h21c, a_p1 = 12'h244;
    localparam logic [11:0] a_cfg = 12'h300, a_sen = 12'h304;
    localparam logic [11:0] a_flg = 12'h308, a_mode = 12'h30c;
    localparam logic [11:0] a_ist = 12'h310, a_iclr = 12'h314;
    localparam logic [11:0] a_ien = 12'h318;
    localparam logic [1:0] ok = 2'b00, er = 2'b10;
    logic sys_clk, reset, awvalid, awready, wvalid, wready, bvalid;
    logic bready, arvalid, arready, rvalid, rready, cpu_run;
    logic fast_osc_en, slow_osc_en, sys_clk_en, periph_clk_en;
    logic cpu_irq_req, irq, slow_clk_tick;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic [2:0] mode_state;
    logic [7:0] port0_pin, port1_pin;
    logic [6:0] source_event;
    logic [2:0] prot;
    logic [3:0] wstrb;
    int n_fail, check_count, n;

    power_mode_wakeup_control #(
        .ADDR_W(12), .EXT_HS_CLKS(EXT), .INT_HS_CLKS(HS), .LS_CLKS(LS)
    ) u_dut (
        .sys_clk(sys_clk), .reset(reset),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_awaddr(awaddr), .s_axi_awprot(prot),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_araddr(araddr),
        .s_axi_arprot(prot), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .port0_pin(port0_pin),
        .port1_pin(port1_pin), .source_event(source_event),
        .slow_clk_tick(slow_clk_tick), .cpu_run(cpu_run),
        .fast_osc_en(fast_osc_en), .slow_osc_en(slow_osc_en),
        .sys_clk_en(sys_clk_en), .periph_clk_en(periph_clk_en),
        .mode_state(mode_state), .cpu_irq_req(cpu_irq_req), .irq(irq)
    );

    pin_event_model u_pins (
        .sys_clk(sys_clk), .slow_osc_en(slow_osc_en),
        .port0_pin(port0_pin), .port1_pin(port1_pin),
        .source_event(source_event), .slow_clk_tick(slow_clk_tick)
    );

    task check(input string nm, input logic [31:0] s, e);
        check_count++;
        if (s !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask

    task test_done;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] r);
        int t;
        t = 0;
        @(posedge sys_clk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= v;
        bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            t++;
        end while (bvalid !== 1'b1 && t < 100);
        bready <= 1'b0;
        if (t >= 100) begin n_fail++; test_done; end
        check("bresp", {30'h0, bresp}, {30'h0, r});
    endtask

    task rd(input string nm, input logic [11:0] a, input logic [31:0] e,
            input logic [1:0] r);
        int t;
        t = 0;
        @(posedge sys_clk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            t++;
        end while (rvalid !== 1'b1 && t < 100);
        rready <= 1'b0;
        if (t >= 100) begin n_fail++; test_done; end
        check("rresp", {30'h0, rresp}, {30'h0, r});
        check(nm, rdata, e);
    endtask

    // Cycles from the last pin change until the CPU runs again
    task wait_run;
        n = 0;
        while (cpu_run !== 1'b1 && n < 200) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 200) begin n_fail++; test_done; end
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial begin
        {reset, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
        {awaddr, araddr, wdata, prot, wstrb} = 63'hf;
        n_fail = 0;
        check_count = 0;
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
        rd("power_control", a_pc, 32'h0, ok);
        rd("port1_wake", a_p1, 32'h0, ok);
        rd("mode_reset", a_mode, 32'h1, ok);
        wr(a_p1, 32'ha5, ok);
        rd("port1_wake_rw", a_p1, 32'ha5, ok);
        wstrb <= 4'he;
        prot <= 3'h7;
        wr(a_p1, 32'h5a, ok);
        wstrb <= 4'hf;
        rd("strobe_off", a_p1, 32'ha5, ok);
        wr(a_pc, 32'h4, ok);
        rd("gp_flag", a_pc, 32'h4, ok);
        wr(a_mode, 32'h4, er);
        rd("unmapped", 12'h000, 32'h0, er);
        $display("test registers done");
        wr(a_ien, 32'h7, ok);
        wr(a_p1, 32'h0, ok);
        wr(a_pc, 32'h2, ok);
        rd("stop_mode", a_mode, 32'h4, ok);
        check("fast_osc", {31'h0, fast_osc_en}, 32'h0);
        check("irq_entry", {31'h0, irq}, 32'h1);
        u_pins.flip1(3);
        repeat (6) @(posedge sys_clk);
        rd("stop_held", a_mode, 32'h4, ok);
        u_pins.flip0(5);
        wait_run;
        check("settle_int", {31'h0, n >= HS + 3 * LS + 1 &&
            n <= HS + 3 * LS + 3}, 32'h1);
        rd("stop_cleared", a_pc, 32'h0, ok);
        rd("wake_flag", a_flg, 32'h80, ok);
        rd("int_status", a_ist, 32'h5, ok);
        wr(a_ien, 32'h0, ok);
        check("irq_masked", {31'h0, irq}, 32'h0);
        wr(a_iclr, 32'h5, ok);
        rd("int_cleared", a_ist, 32'h0, ok);
        wr(a_ien, 32'h7, ok);
        $display("test stop done");
        wr(a_cfg, 32'h2, ok);
        wr(a_p1, 32'h08, ok);
        wr(a_pc, 32'h3, ok);
        rd("stop_and_idle", a_mode, 32'h4, ok);
        u_pins.flip1(3);
        wait_run;
        check("settle_ext", {31'h0, n >= EXT + 3 * LS + 1 &&
            n <= EXT + 3 * LS + 3}, 32'h1);
        rd("both_cleared", a_pc, 32'h0, ok);
        rd("normal_again", a_mode, 32'h1, ok);
        wr(a_cfg, 32'h0, ok);
        wr(a_flg, 32'hff, ok);
        $display("test external settle done");
        wr(a_sen, 32'h01, ok);
        wr(a_pc, 32'h1, ok);
        rd("idle_mode", a_mode, 32'h2, ok);
        check("periph_clk", {31'h0, periph_clk_en}, 32'h1);
        u_pins.pulse(0);
        rd("idle_held", a_mode, 32'h2, ok);
        rd("event_flag", a_flg, 32'h01, ok);
        check("no_request", {31'h0, cpu_irq_req}, 32'h0);
        wr(a_cfg, 32'h1, ok);
        rd("irq_wake", a_mode, 32'h1, ok);
        rd("idle_cleared", a_pc, 32'h0, ok);
        check("request", {31'h0, cpu_irq_req}, 32'h1);
        wr(a_flg, 32'hff, ok);
        wr(a_pc, 32'h1, ok);
        u_pins.flip0(2);
        wait_run;
        check("idle_wake_time", n, 32'h2);
        rd("pin_idle_wake", a_pc, 32'h0, ok);
        rd("int_status_all", a_ist, 32'h7, ok);
        wr(a_iclr, 32'h7, ok);
        check("irq_cleared", {31'h0, irq}, 32'h0);
        $display("test idle done");
        test_done;
    end
endmodule
`default_nettype wire
